//--- core/pas_pkg.sv
// constants, field layout and register offsets of the pwm auto-shutdown block
// assumes a single 50 MHz clock domain and a plain strobe register port
package pas_pkg;
  localparam int          addr_width     = 4;
  localparam int          data_width     = 16;
  // =====================================================
  // register offsets
  localparam logic [3:0]  off_control    = 4'h0;
  localparam logic [3:0]  off_period     = 4'h1;
  localparam logic [3:0]  off_duty       = 4'h2;
  localparam logic [3:0]  off_irq_status = 4'h3;
  localparam logic [3:0]  off_irq_mask   = 4'h4;
  localparam logic [3:0]  off_live       = 4'h5;
  // =====================================================
  // control field positions
  localparam int          pos_flag       = 7;
  localparam int          pos_src_lo     = 4;
  localparam int          pos_ac_lo      = 2;
  localparam int          pos_bd_lo      = 0;
  localparam int          pos_restart    = 8;
  localparam int          pos_enable     = 9;
  localparam logic [15:0] control_reset  = 16'h0000;
  localparam logic [15:0] period_reset   = 16'h00FF;
  localparam logic [15:0] duty_reset     = 16'h0080;
  // =====================================================
  // source codes
  localparam logic [2:0]  src_off        = 3'h0;
  localparam logic [2:0]  src_cmp1       = 3'h1;
  localparam logic [2:0]  src_cmp2       = 3'h2;
  localparam logic [2:0]  src_cmp_any    = 3'h3;
  localparam logic [2:0]  src_fault      = 3'h4;
  localparam logic [2:0]  src_fault_c2   = 3'h5;
  localparam logic [2:0]  src_fault_c1   = 3'h6;
  localparam logic [2:0]  src_fault_any  = 3'h7;
  // =====================================================
  // pin-state codes and interrupt bits
  localparam logic [1:0]  pin_low        = 2'h0;
  localparam logic [1:0]  pin_high       = 2'h1;
  localparam int          irq_shutdown   = 0;
  localparam int          irq_period     = 1;
  localparam int          irq_width      = 2;
  typedef enum logic [0:0] {pas_run, pas_shut} pas_state_type;
endpackage

//--- core/pas_pin_stage.sv
// one output pin: pwm level or programmed shutdown state
// assumes shut and code are steady registered controls
`timescale 1ns/1ps
module pas_pin_stage
  import pas_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       pwm,
  input  wire logic       shut,
  input  wire logic [1:0] code,
  output logic            pin_out,
  output logic            pin_oe
);
  typedef struct packed
  {
    logic out;
    logic oe;
  } pas_pin_type;
  pas_pin_type st;
  pas_pin_type next_st;
  always_comb
  begin
    next_st.out = pwm;
    next_st.oe  = 1'b1;
    if (shut)
    begin
      next_st.out = (code == pin_high);
      next_st.oe  = ~code[1];
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end
  assign pin_out = st.out;
  assign pin_oe  = st.oe;
endmodule

//--- core/pas_top.sv
// pwm generator with auto-shutdown, register port and interrupt
// assumes comparator and fault inputs are synchronous to clk
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module pas_top
  import pas_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic [pas_pkg::addr_width-1:0] addr,
  input  wire logic [pas_pkg::data_width-1:0] wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [pas_pkg::data_width-1:0] rdata,
  input  wire logic                           fault_input_pin,
  input  wire logic                           comparator_one_out,
  input  wire logic                           comparator_two_out,
  output logic                                pwm_out_a,
  output logic                                pwm_out_a_oe,
  output logic                                pwm_out_b,
  output logic                                pwm_out_b_oe,
  output logic                                pwm_out_c,
  output logic                                pwm_out_c_oe,
  output logic                                pwm_out_d,
  output logic                                pwm_out_d_oe,
  output logic                                irq
);
  import pas_pkg::*;
  // =====================================================
  // state
  typedef struct packed
  {
    pas_state_type        mode;
    logic [15:0]          control;
    logic [15:0]          period;
    logic [15:0]          duty;
    logic [15:0]          count;
    logic [irq_width-1:0] status;
    logic [irq_width-1:0] mask;
    logic [15:0]          rdata;
    logic                 irq;
  } pas_top_type;
  pas_top_type st;
  pas_top_type next_st;
  logic        cond;
  logic        pwm_level;
  logic        wrap;
  logic        shut;
  logic [2:0]  src;
  // source decode, fault pin active low
  function automatic logic src_hit(input logic [2:0] s, input logic flt_n,
                                   input logic c1, input logic c2);
    logic f;
    f = ~flt_n;
    unique case (s)
      src_off:       src_hit = 1'b0;
      src_cmp1:      src_hit = c1;
      src_cmp2:      src_hit = c2;
      src_cmp_any:   src_hit = c1 | c2;
      src_fault:     src_hit = f;
      src_fault_c2:  src_hit = f | c2;
      src_fault_c1:  src_hit = f | c1;
      src_fault_any: src_hit = f | c1 | c2;
    endcase
  endfunction
  assign src       = st.control[pos_src_lo+:3];
  assign cond      = src_hit(src, fault_input_pin, comparator_one_out, comparator_two_out);
  assign wrap      = (st.count >= st.period);
  assign pwm_level = st.control[pos_enable] & (st.count < st.duty);
  assign shut      = (st.mode == pas_shut);
  // =====================================================
  // next state
  always_comb
  begin
    next_st       = st;
    next_st.rdata = '0;
    next_st.count = wrap ? 16'h0000 : st.count + 16'h0001;
    if (wr)
    begin
      unique case (addr)
        off_control:
        begin
          next_st.control[6:0]       = wdata[6:0];
          next_st.control[pos_restart] = wdata[pos_restart];
          next_st.control[pos_enable]  = wdata[pos_enable];
          if (!cond)
            next_st.control[pos_flag] = wdata[pos_flag];
        end
        off_period:   next_st.period = wdata;
        off_duty:     next_st.duty   = wdata;
        off_irq_status: next_st.status = st.status & ~wdata[irq_width-1:0];
        off_irq_mask:   next_st.mask   = wdata[irq_width-1:0];
        default:      next_st.rdata  = '0;
      endcase
    end
    if (cond)
      next_st.control[pos_flag] = 1'b1;
    else if (st.control[pos_restart] && wrap)
      next_st.control[pos_flag] = 1'b0;
    // shut now, resume only at period start
    unique case (st.mode)
      pas_run:
        if (next_st.control[pos_flag])
          next_st.mode = pas_shut;
      pas_shut:
        if (!st.control[pos_flag] && !cond && wrap)
          next_st.mode = pas_run;
    endcase
    // set wins over the write-one clear
    if (cond && !st.control[pos_flag])
      next_st.status[irq_shutdown] = 1'b1;
    if (wrap)
      next_st.status[irq_period] = 1'b1;
    if (rd)
    begin
      unique case (addr)
        off_control:    next_st.rdata = {6'h00, st.control[9:0]};
        off_period:     next_st.rdata = st.period;
        off_duty:       next_st.rdata = st.duty;
        off_irq_status: next_st.rdata = {14'h0000, st.status};
        off_irq_mask:   next_st.rdata = {14'h0000, st.mask};
        off_live:       next_st.rdata = {12'h000, comparator_two_out, comparator_one_out,
                                         fault_input_pin, shut};
        default:        next_st.rdata = '0;
      endcase
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st         <= '0;
      st.mode    <= pas_run;
      st.control <= control_reset;
      st.period  <= period_reset;
      st.duty    <= duty_reset;
    end
    else
      st <= next_st;
  end
  assign rdata = st.rdata;
  assign irq   = st.irq;
  // =====================================================
  // pin stages, a/c share one field, b/d the other
  logic [3:0] pin_o;
  logic [3:0] pin_e;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      pas_pin_stage u_pin
      (
        .clk     (clk),
        .nrst    (nrst),
        .pwm     ((g % 2 == 0) ? pwm_level : ~pwm_level),
        .shut    (shut),
        .code    ((g % 2 == 0) ? st.control[pos_ac_lo+:2] : st.control[pos_bd_lo+:2]),
        .pin_out (pin_o[g]),
        .pin_oe  (pin_e[g])
      );
    end
  endgenerate
  assign pwm_out_a    = pin_o[0];
  assign pwm_out_b    = pin_o[1];
  assign pwm_out_c    = pin_o[2];
  assign pwm_out_d    = pin_o[3];
  assign pwm_out_a_oe = pin_e[0];
  assign pwm_out_b_oe = pin_e[1];
  assign pwm_out_c_oe = pin_e[2];
  assign pwm_out_d_oe = pin_e[3];
  // =====================================================
  // checks
  // flag forces shutdown
  shut_follows_a: assert property (@(posedge clk) disable iff (!nrst)
    st.control[pos_flag] |=> shut) else $error("flag set but outputs not shut");
  run_drives_a: assert property (@(posedge clk) disable iff (!nrst)
    !shut |=> (pwm_out_a_oe && pwm_out_b_oe && pwm_out_a == $past(pwm_level)))
    else $error("outputs not following pwm while running");
  level_holds_a: assert property (@(posedge clk) disable iff (!nrst)
    cond |=> st.control[pos_flag]) else $error("flag dropped under condition");
  write_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == off_control && !wdata[pos_flag] && cond) |=> st.control[pos_flag])
    else $error("flag cleared while condition present");
  resume_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(shut) |-> $past(wrap)) else $error("resumed off period boundary");
  restart_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (st.control[pos_restart] && wrap && !cond) |=> !st.control[pos_flag])
    else $error("auto restart left flag set");
  fault_trip_a: assert property (@(posedge clk) disable iff (!nrst)
    (src == src_fault && !fault_input_pin) |=> ##1 shut) else $error("fault low missed");
  cmp_two_a: assert property (@(posedge clk) disable iff (!nrst)
    (src == src_cmp2 && comparator_two_out) |=> st.control[pos_flag])
    else $error("comparator two missed");
  cmp_any_a: assert property (@(posedge clk) disable iff (!nrst)
    (src == src_cmp_any && (comparator_one_out || comparator_two_out))
    |=> st.control[pos_flag])
    else $error("comparator pair missed");
  tri_state_a: assert property (@(posedge clk) disable iff (!nrst)
    (shut && st.control[pos_ac_lo+1] && $stable(st.control)) |=> !pwm_out_a_oe)
    else $error("pair a/c not released");
  drive_high_a: assert property (@(posedge clk) disable iff (!nrst)
    (shut && st.control[pos_bd_lo+:2] == pin_high)
    |=> (pwm_out_b && pwm_out_b_oe && pwm_out_d && pwm_out_d_oe))
    else $error("pair b/d not driven high");
  drive_low_a: assert property (@(posedge clk) disable iff (!nrst)
    (shut && st.control[pos_ac_lo+:2] == pin_low)
    |=> (!pwm_out_a && !pwm_out_c && pwm_out_a_oe && pwm_out_c_oe))
    else $error("pair a/c not driven low");
  irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
    irq == |(st.status & st.mask)) else $error("irq mismatch");
  // set must win over a same-cycle write-one clear
  event_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (cond && !st.control[pos_flag]) |=> st.status[irq_shutdown])
    else $error("shutdown event not recorded");
  shut_seen_c:    cover property (@(posedge clk) disable iff (!nrst) $rose(shut));
  resume_seen_c:  cover property (@(posedge clk) disable iff (!nrst) $fell(shut));
  lock_seen_c:    cover property (@(posedge clk) disable iff (!nrst)
    wr && addr == off_control && cond);
  restart_seen_c: cover property (@(posedge clk) disable iff (!nrst)
    st.control[pos_restart] && st.control[pos_flag] && wrap && !cond);
endmodule

//--- test/pas_far_side.sv
// far side model: fault pin and two comparator outputs
// assumes the bench commands it just after a clk edge
`timescale 1ns/1ps
module pas_far_side
(
  input  wire logic       clk,
  input  wire logic       fault_on,
  input  wire logic [1:0] cmp_on,
  output logic            fault_input_pin,
  output logic            comparator_one_out,
  output logic            comparator_two_out
);
  // fault is a low level on the pin, comparators trip high
  always_ff @(posedge clk)
  begin
    fault_input_pin    <= !fault_on;
    comparator_one_out <= cmp_on[0];
    comparator_two_out <= cmp_on[1];
  end
endmodule

//--- test/test_pas_top.sv
// self-checking bench of the pwm auto-shutdown block
// assumes pas_top and the far side model are compiled first
`timescale 1ns/1ps
module test_pas_top;
  import pas_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, f_on = 0;
  logic [1:0] c_on = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, rdata, d;
  logic flt, c1, c2, a, a_oe, b, b_oe, c, c_oe, e, e_oe, irq;
  int fail_count = 0, compares = 0;
  always #10 clk = ~clk;
  pas_far_side i_far (.clk(clk), .fault_on(f_on), .cmp_on(c_on), .fault_input_pin(flt),
    .comparator_one_out(c1), .comparator_two_out(c2));
  pas_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fault_input_pin(flt), .comparator_one_out(c1),
    .comparator_two_out(c2), .pwm_out_a(a), .pwm_out_a_oe(a_oe), .pwm_out_b(b),
    .pwm_out_b_oe(b_oe), .pwm_out_c(c), .pwm_out_c_oe(c_oe), .pwm_out_d(e),
    .pwm_out_d_oe(e_oe), .irq(irq));
  // ==========================================
  // bus and check tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] ad, input logic [15:0] v);
    @(posedge clk);
    wr <= 1; addr <= ad; wdata <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [3:0] ad);
    @(posedge clk);
    rd <= 1; addr <= ad;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic src(input logic [2:0] v);
    @(posedge clk);
    {c_on, f_on} <= v;
  endtask
  // enabled control word, flag written as zero
  function automatic logic [15:0] ctl(input logic [2:0] s, input logic [1:0] ac, bd);
    return 16'h0200 | {9'h000, s, ac, bd};
  endfunction
  function automatic logic trip(input logic [2:0] s, input logic [2:0] v);
    case (s)
      3'h1: return v[1];
      3'h2: return v[2];
      3'h3: return v[1] | v[2];
      3'h4: return v[0];
      3'h5: return v[0] | v[2];
      3'h6: return v[0] | v[1];
      3'h7: return |v;
      default: return 1'b0;
    endcase
  endfunction
  task automatic release_all(input logic [15:0] cw);
    src(3'h0);
    tick(3);
    wreg(off_control, cw);
    tick(8);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    rreg(off_control); chk(d, 16'h0000);
    rreg(off_period); chk(d, 16'h00FF);
    rreg(off_duty); chk(d, 16'h0080);
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF); chk(d, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_sources;
    for (int s = 0; s < 8; s++)
      for (int v = 0; v < 8; v++)
      begin
        wreg(off_control, ctl(s, 2'h2, 2'h1));
        src(v);
        tick(5);
        chk(a_oe, !trip(s, v));
        rreg(off_control); chk(d[7], trip(s, v));
        release_all(ctl(s, 2'h2, 2'h1));
      end
    $display("test sources done");
  endtask
  task automatic t_level_resume;
    int n;
    wreg(off_control, ctl(src_fault, 2'h2, 2'h1));
    src(3'h1);
    tick(12);
    wreg(off_control, ctl(src_fault, 2'h2, 2'h1));
    rreg(off_control); chk(d[7], 1'b1);
    chk(a_oe, 1'b0);
    src(3'h0);
    tick(3);
    wreg(off_control, ctl(src_fault, 2'h2, 2'h1));
    n = 0;
    while (a_oe !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(a_oe, 1'b1);
    chk(a, 1'b1);
    tick(1);
    chk(a, 1'b1);
    tick(1);
    chk(a, 1'b0);
    $display("test level resume done");
  endtask
  task automatic t_pairs;
    for (int k = 0; k < 4; k++)
    begin
      wreg(off_control, ctl(src_fault, k, k));
      src(3'h1);
      tick(5);
      chk({a_oe, c_oe, b_oe, e_oe}, {4{~k[1]}});
      if (!k[1]) chk({a, c, b, e}, {4{k[0]}});
      release_all(ctl(src_fault, k, k));
    end
    $display("test pairs done");
  endtask
  task automatic t_irq;
    wreg(off_irq_status, 16'h0003);
    wreg(off_irq_mask, 16'h0001);
    wreg(off_control, ctl(src_cmp_any, 2'h0, 2'h0));
    src(3'h4);
    tick(5);
    chk(irq, 1'b1);
    wreg(off_irq_mask, 16'h0000);
    tick(2);
    chk(irq, 1'b0);
    wreg(off_irq_mask, 16'h0001);
    release_all(ctl(src_cmp_any, 2'h0, 2'h0));
    wreg(off_irq_status, 16'h0001);
    tick(2);
    chk(irq, 1'b0);
    rreg(off_irq_status); chk(d[0], 1'b0);
    $display("test irq done");
  endtask
  // flag clears itself at a wrap once the comparator drops
  task automatic t_auto_restart;
    int n;
    wreg(off_control, 16'h0100 | ctl(src_cmp1, 2'h2, 2'h0));
    src(3'h2);
    tick(6);
    rreg(off_control); chk(d[8:7], 2'h3);
    chk(a_oe, 1'b0);
    rreg(off_live); chk(d[3:0], 4'h7);
    src(3'h0);
    n = 0;
    while (a_oe !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(a_oe, 1'b1);
    chk(a, 1'b1);
    rreg(off_control); chk(d[7], 1'b0);
    release_all(ctl(src_cmp1, 2'h2, 2'h0));
    $display("test auto restart done");
  endtask
  task automatic stop_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    t_regs;
    wreg(off_period, 16'h0004);
    wreg(off_duty, 16'h0002);
    t_sources;
    t_level_resume;
    t_pairs;
    t_irq;
    t_auto_restart;
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end
endmodule
